// >>> core/jam_sync_params.svh
`ifndef JAM_SYNC_PARAMS_SVH
`define JAM_SYNC_PARAMS_SVH

// Register offsets (word index on the plain register port)
`define JAM_REG_MODE      4'h0
`define JAM_REG_CONTENT   4'h1
`define JAM_REG_WHEEL     4'h2
`define JAM_REG_STATUS    4'h3
`define JAM_REG_GEN_TIME  4'h4
`define JAM_REG_GEN_USER  4'h5

// Reset values
`define JAM_MODE_RST      4'h0
`define JAM_CONTENT_RST   3'h0
`define JAM_WHEEL_RST     5'h04

// Threshold limits in frames
`define JAM_THR_MIN       5'h02
`define JAM_THR_MAX       5'h14
`define JAM_THR_DEFAULT   5'h04

// Capture window after a large difference
`define JAM_CAPTURE_SECONDS 2

// Field layout of a BCD time word {hh,mm,ss,ff}
`define JAM_FRAME_MSB     7
`define JAM_FRAME_LSB     0

`endif

// >>> core/jam_sync_pkg.sv
package jam_sync_pkg;

    typedef enum logic [3:0] {
        MODE_OFF        = 4'b0000,
        MODE_SINGLE     = 4'b0001,
        MODE_CONTINUOUS = 4'b0010,
        MODE_ONE_FRAME  = 4'b0011,
        MODE_PROGRAMMED = 4'b0100,
        MODE_STARTUP    = 4'b0101,
        MODE_CONVERT    = 4'b0110,
        MODE_DIFF_CONT  = 4'b0111,
        MODE_DIFF_STOP  = 4'b1000,
        MODE_ZERO_FRAME = 4'b1001
    } jam_mode_type;

    typedef enum logic [2:0] {
        CONTENT_TIME      = 3'b000,
        CONTENT_USER      = 3'b001,
        CONTENT_BOTH      = 3'b010,
        CONTENT_TIME2USER = 3'b011,
        CONTENT_USER2TIME = 3'b100
    } jam_content_type;

endpackage

// >>> core/frame_diff_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "jam_sync_params.svh"

module frame_diff_calc #(
    parameter int FPS = 25
) (
    input wire logic i_sys_clk,
    input wire logic i_ce,
    input wire logic [31:0] i_rd_time,
    input wire logic [31:0] i_gen_time,
    output logic [23:0] o_rd_frames_q,
    output logic [23:0] o_gen_frames_q
);

    // ----------------------------------------
    // BCD time to linear frame count
    // ----------------------------------------
    function automatic logic [23:0] to_frames(input logic [31:0] t);
        logic [23:0] h;
        logic [23:0] m;
        logic [23:0] s;
        logic [23:0] f;
        h = 24'(t[31:28]) * 24'd10 + 24'(t[27:24]);
        m = 24'(t[23:20]) * 24'd10 + 24'(t[19:16]);
        s = 24'(t[15:12]) * 24'd10 + 24'(t[11:8]);
        f = 24'(t[7:4]) * 24'd10 + 24'(t[3:0]);
        to_frames = ((h * 24'd60 + m) * 24'd60 + s) * 24'(FPS) + f;
    endfunction

    // Registered so the wide multiply stays off the decision path
    always_ff @(posedge i_sys_clk) begin
        if (i_ce) begin
            o_rd_frames_q <= to_frames(i_rd_time);
            o_gen_frames_q <= to_frames(i_gen_time);
        end
    end

endmodule

`default_nettype wire

// >>> core/timecode_jam_sync_control.sv
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "jam_sync_params.svh"

module timecode_jam_sync_control
    import jam_sync_pkg::*;
#(
    parameter int FPS = 25,
    parameter int DROP_CNT_W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata_q,
    input wire logic i_frame_tick,
    input wire logic i_rd_valid,
    input wire logic [31:0] i_rd_time,
    input wire logic [31:0] i_rd_user,
    input wire logic i_gen_locked,
    input wire logic [31:0] i_gen_time,
    input wire logic [31:0] i_gen_user,
    output logic o_load_time_q,
    output logic [31:0] o_load_time_val_q,
    output logic o_load_user_q,
    output logic [31:0] o_load_user_val_q,
    output logic o_gen_stop_q,
    output logic o_jam_active_q
);

    // ----------------------------------------
    // Derived constants
    // ----------------------------------------
    localparam logic [15:0] CAPTURE_FRAMES = 16'(`JAM_CAPTURE_SECONDS * FPS);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    jam_mode_type mode_q;
    jam_content_type content_q;
    logic [4:0] wheel_q;
    logic startup_done_q;
    logic [DROP_CNT_W-1:0] miss_q;
    logic seen_word_q;
    logic [15:0] capture_q;
    logic have_last_q;
    logic pend_q;
    logic [31:0] pend_time_q;
    logic [31:0] pend_user_q;
    logic [23:0] rd_frames;
    logic [23:0] gen_frames;
    logic [23:0] last_frames_q;

    frame_diff_calc #(
        .FPS(FPS)
    ) u_frames (
        .i_sys_clk(i_sys_clk),
        .i_ce(i_ce),
        .i_rd_time(pend_time_q),
        .i_gen_time(i_gen_time),
        .o_rd_frames_q(rd_frames),
        .o_gen_frames_q(gen_frames)
    );

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic bcd_ok(input logic [31:0] t);
        logic ok;
        ok = (t[31:28] <= 4'h2) && (t[27:24] <= 4'h9) && (t[23:20] <= 4'h5) && (t[19:16] <= 4'h9);
        ok = ok && (t[15:12] <= 4'h5) && (t[11:8] <= 4'h9) && (t[7:4] <= 4'h9) && (t[3:0] <= 4'h9);
        bcd_ok = ok;
    endfunction

    function automatic logic [23:0] abs_diff(input logic [23:0] a, input logic [23:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [4:0] thr_of(input logic [4:0] w);
        thr_of = (w < `JAM_THR_MIN || w > `JAM_THR_MAX) ? `JAM_THR_DEFAULT : w;
    endfunction

    // ----------------------------------------
    // Decision logic
    // ----------------------------------------
    logic is_diff;
    logic ascending;
    logic plausible;
    logic diff_big;
    logic accept;
    logic stop_now;
    logic [23:0] diff;

    always_comb begin
        is_diff = (mode_q == MODE_DIFF_CONT) || (mode_q == MODE_DIFF_STOP);
        diff = abs_diff(rd_frames, gen_frames);
        ascending = !have_last_q || (rd_frames == last_frames_q + 24'h00_0001);
        if (is_diff) begin
            ascending = !have_last_q || (rd_frames > last_frames_q);
        end
        plausible = bcd_ok(pend_time_q) && ascending;
        diff_big = diff >= 24'(thr_of(wheel_q));
        accept = 1'b0;
        unique case (mode_q)
            MODE_OFF: accept = 1'b0;
            MODE_SINGLE: accept = plausible;
            MODE_CONTINUOUS: accept = plausible;
            MODE_ONE_FRAME: accept = plausible;
            MODE_PROGRAMMED: accept = plausible;
            MODE_STARTUP: accept = plausible && i_gen_locked && !startup_done_q;
            MODE_CONVERT: accept = 1'b1;
            MODE_DIFF_CONT,
            MODE_DIFF_STOP: accept = plausible && (diff_big || capture_q != 16'h0000);
            MODE_ZERO_FRAME: accept = plausible && (pend_time_q[`JAM_FRAME_MSB:`JAM_FRAME_LSB] == 8'h00);
            default: accept = 1'b0;
        endcase
        stop_now = 1'b0;
        unique case (mode_q)
            MODE_ONE_FRAME: stop_now = (miss_q > DROP_CNT_W'(1));
            MODE_PROGRAMMED: stop_now = (miss_q > DROP_CNT_W'(wheel_q));
            MODE_DIFF_STOP: stop_now = (miss_q > DROP_CNT_W'(wheel_q));
            MODE_CONVERT: stop_now = (miss_q != '0);
            default: stop_now = 1'b0;
        endcase
        // Dropout stop is held off for user-bits-only content, except in convert mode
        if (mode_q != MODE_CONVERT && content_q == CONTENT_USER) begin
            stop_now = 1'b0;
        end
    end

    // ----------------------------------------
    // Reader word pipeline (one stage to match the frame converter)
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            pend_time_q <= 32'h0000_0000;
            pend_user_q <= 32'h0000_0000;
        end else if (i_ce) begin
            pend_q <= i_rd_valid;
            if (i_rd_valid) begin
                pend_time_q <= i_rd_time;
                pend_user_q <= i_rd_user;
            end
        end
    end

    // Converter output lags pend by one cycle; act on the lagged strobe
    logic act_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            act_q <= 1'b0;
        end else if (i_ce) begin
            act_q <= pend_q;
        end
    end

    // ----------------------------------------
    // Continuity history
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            have_last_q <= 1'b0;
            last_frames_q <= 24'h00_0000;
        end else if (i_ce && act_q) begin
            have_last_q <= 1'b1;
            last_frames_q <= rd_frames;
        end
    end

    // ----------------------------------------
    // Dropout counter
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            miss_q <= '0;
            seen_word_q <= 1'b0;
        end else if (i_ce) begin
            if (i_rd_valid) begin
                seen_word_q <= 1'b1;
                miss_q <= '0;
            end else if (i_frame_tick) begin
                seen_word_q <= 1'b0;
                // Saturate so a long silence never wraps back to running
                if (!seen_word_q && miss_q != '1) begin
                    miss_q <= miss_q + DROP_CNT_W'(1);
                end
            end
        end
    end

    // ----------------------------------------
    // Capture window
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            capture_q <= 16'h0000;
        end else if (i_ce) begin
            if (act_q && is_diff && plausible && diff_big) begin
                capture_q <= CAPTURE_FRAMES;
            end else if (i_frame_tick && capture_q != 16'h0000) begin
                capture_q <= capture_q - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            // Start-up mode outlives a restart so its single transfer repeats
            if (mode_q == MODE_STARTUP) begin
                mode_q <= MODE_STARTUP;
            end else begin
                mode_q <= MODE_OFF;
            end
            content_q <= jam_content_type'(`JAM_CONTENT_RST);
            wheel_q <= `JAM_WHEEL_RST;
        end else if (i_ce) begin
            if (i_wr && i_addr == `JAM_REG_MODE) begin
                mode_q <= jam_mode_type'(i_wdata[3:0]);
            end else if (act_q && accept && mode_q == MODE_SINGLE) begin
                mode_q <= MODE_OFF;
            end
            if (i_wr && i_addr == `JAM_REG_CONTENT) begin
                content_q <= jam_content_type'(i_wdata[2:0]);
            end
            if (i_wr && i_addr == `JAM_REG_WHEEL) begin
                wheel_q <= i_wdata[4:0];
            end
        end
    end

    // Start-up transfer flag: cleared at every start-up, mode itself kept
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            startup_done_q <= 1'b0;
        end else if (i_ce && act_q && accept && mode_q == MODE_STARTUP) begin
            startup_done_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rdata_q <= 32'h0000_0000;
            if (i_rd) begin
                unique case (i_addr)
                    `JAM_REG_MODE: o_rdata_q <= {28'h000_0000, mode_q};
                    `JAM_REG_CONTENT: o_rdata_q <= {29'h000_0000, content_q};
                    `JAM_REG_WHEEL: o_rdata_q <= {27'h000_0000, wheel_q};
                    `JAM_REG_STATUS: o_rdata_q <= {16'h0000, capture_q[7:0], 3'h0, o_gen_stop_q,
                                                    startup_done_q, o_jam_active_q, i_gen_locked,
                                                    (miss_q != '0)};
                    `JAM_REG_GEN_TIME: o_rdata_q <= i_gen_time;
                    `JAM_REG_GEN_USER: o_rdata_q <= i_gen_user;
                    default: o_rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Generator load and stop
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_load_time_q <= 1'b0;
            o_load_user_q <= 1'b0;
            o_load_time_val_q <= 32'h0000_0000;
            o_load_user_val_q <= 32'h0000_0000;
        end else if (i_ce) begin
            o_load_time_q <= 1'b0;
            o_load_user_q <= 1'b0;
            if (act_q && accept) begin
                unique case (content_q)
                    CONTENT_TIME: begin
                        o_load_time_q <= 1'b1;
                        o_load_time_val_q <= pend_time_q;
                    end
                    CONTENT_USER: begin
                        o_load_user_q <= 1'b1;
                        o_load_user_val_q <= pend_user_q;
                    end
                    CONTENT_BOTH: begin
                        o_load_time_q <= 1'b1;
                        o_load_time_val_q <= pend_time_q;
                        o_load_user_q <= 1'b1;
                        o_load_user_val_q <= pend_user_q;
                    end
                    CONTENT_TIME2USER: begin
                        o_load_user_q <= 1'b1;
                        o_load_user_val_q <= pend_time_q;
                    end
                    CONTENT_USER2TIME: begin
                        o_load_time_q <= 1'b1;
                        o_load_time_val_q <= pend_user_q;
                    end
                    default: begin
                        o_load_time_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_gen_stop_q <= 1'b0;
            o_jam_active_q <= 1'b0;
        end else if (i_ce) begin
            o_gen_stop_q <= stop_now;
            o_jam_active_q <= (mode_q != MODE_OFF);
        end
    end

endmodule

`default_nettype wire

// >>> test/timecode_jam_sync_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module timecode_jam_sync_control_checker
    import jam_sync_pkg::*;
#(
    parameter int FPS = 25,
    parameter int DROP_CNT_W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata_q,
    input wire logic i_frame_tick,
    input wire logic i_rd_valid,
    input wire logic [31:0] i_rd_time,
    input wire logic [31:0] i_rd_user,
    input wire logic i_gen_locked,
    input wire logic [31:0] i_gen_time,
    input wire logic [31:0] i_gen_user,
    input wire logic o_load_time_q,
    input wire logic [31:0] o_load_time_val_q,
    input wire logic o_load_user_q,
    input wire logic [31:0] o_load_user_val_q,
    input wire logic o_gen_stop_q,
    input wire logic o_jam_active_q
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // ----------------
    // Mode seen from writes
    // ----------------
    // Only writes are mirrored, so the one-shot auto clear is not tracked here
    logic conv_q;
    logic single_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            conv_q <= 1'b0;
            single_q <= 1'b0;
        end else if (i_ce && i_wr && i_addr == 4'h0) begin
            conv_q <= i_wdata[3:0] == MODE_CONVERT;
            single_q <= i_wdata[3:0] == MODE_SINGLE;
        end
    end
    // Kept through reset on purpose: start-up mode must survive it
    logic start_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && i_wr && i_addr == 4'h0) begin
            start_q <= i_wdata[3:0] == MODE_STARTUP;
        end
    end
    // ----------------
    // Properties
    // ----------------
    property p_reset_clear;
        disable iff (1'b0) i_rst && i_ce |=> !o_jam_active_q && !o_load_time_q && !o_gen_stop_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
    property p_rdata_idle;
        i_ce && !i_rd |=> o_rdata_q == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    property p_mode_active;
        i_ce && i_wr && i_addr == 4'h0 |-> ##2 o_jam_active_q == ($past(i_wdata[3:0], 2) != 4'h0);
    endproperty
    a_mode_active: assert property (p_mode_active) else $error("active flag does not follow mode");
    property p_load_cause;
        o_load_time_q |-> $past(i_rd_valid, 3);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("load without reader word");
    property p_val_hold;
        !o_load_time_q && !$past(i_rst) |-> $stable(o_load_time_val_q);
    endproperty
    a_val_hold: assert property (p_val_hold) else $error("load value moved without load");
    property p_convert_pass;
        conv_q && i_rd_valid |-> ##3 (o_load_time_q || o_load_user_q);
    endproperty
    a_convert_pass: assert property (p_convert_pass) else $error("convert dropped a word");
    property p_single_off;
        single_q && o_load_time_q |-> ##[1:2] !o_jam_active_q;
    endproperty
    a_single_off: assert property (p_single_off) else $error("one-shot mode stayed on");
    property p_stop_clear;
        i_rd_valid |-> ##[1:3] !o_gen_stop_q;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop held after reader word");
    property p_startup_keep;
        disable iff (1'b0) start_q && i_rst && i_ce ##1 !i_rst && i_ce |=> o_jam_active_q;
    endproperty
    a_startup_keep: assert property (p_startup_keep) else $error("start-up mode lost at reset");
endmodule
bind timecode_jam_sync_control timecode_jam_sync_control_checker #(
    .FPS(FPS),
    .DROP_CNT_W(DROP_CNT_W)
) i_timecode_jam_sync_control_checker (.*);
`default_nettype wire

// >>> test/tc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module tc_link_model (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_rd_en,
    input wire logic i_lock,
    input wire logic [3:0] i_step,
    input wire logic [15:0] i_base,
    input wire logic i_load,
    input wire logic [31:0] i_load_val,
    input wire logic i_stop,
    output logic o_tick,
    output logic o_valid,
    output logic [31:0] o_time,
    output logic [31:0] o_gen_time,
    output logic o_locked
);
    int cyc, rf, gf;
    function automatic logic [31:0] enc(input int f);
        logic [31:0] t;
        t = 32'h0000_0000;
        t[7:4] = 4'((f % 25) / 10);
        t[3:0] = 4'((f % 25) % 10);
        t[15:12] = 4'((f / 25 % 60) / 10);
        t[11:8] = 4'(f / 25 % 10);
        return t;
    endfunction
    function automatic int dec(input logic [31:0] t);
        return (t[15:12] * 10 + t[11:8]) * 25 + t[7:4] * 10 + t[3:0];
    endfunction
    // ----------------
    // Reader and generator
    // ----------------
    // Data lines toggle between words so a stale value never looks valid
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            cyc <= 0;
            rf <= int'(i_base);
            gf <= 0;
            o_tick <= 1'b0;
            o_valid <= 1'b0;
            o_time <= 32'h0000_0000;
        end else begin
            cyc <= (cyc == 11) ? 0 : cyc + 1;
            o_tick <= cyc == 11;
            if (cyc == 11)
                rf <= rf + int'(i_step);
            o_valid <= i_rd_en && cyc == 5;
            o_time <= (i_rd_en && cyc == 5) ? enc(rf) : ~o_time;
            if (i_load)
                gf <= dec(i_load_val);
            else if (o_tick && !i_stop)
                gf <= gf + 1;
        end
    end
    assign o_gen_time = enc(gf);
    assign o_locked = i_lock;
endmodule
`default_nettype wire

// >>> test/timecode_jam_sync_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timecode_jam_sync_control_tb_top;
    import jam_sync_pkg::*;
    logic i_sys_clk, i_rst, i_ce, i_wr, i_rd, i_frame_tick, i_rd_valid, i_gen_locked;
    logic [3:0] i_addr, step;
    logic [31:0] i_wdata, o_rdata_q, i_rd_time, i_rd_user, i_gen_time, i_gen_user, wv;
    logic o_load_time_q, o_load_user_q, o_gen_stop_q, o_jam_active_q, rd_en, lock;
    logic [31:0] o_load_time_val_q, o_load_user_val_q;
    logic [15:0] base;
    int n_errors, total_checks, seed, mode_m, last_m, done_m, f, g, ok, acc, big, thr, cap_m, wh_m;
    int exp_q[$];
    timecode_jam_sync_control i_timecode_jam_sync_control (.*);
    tc_link_model i_tc_link_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rd_en(rd_en), .i_lock(lock),
        .i_step(step), .i_base(base), .i_load(o_load_time_q), .i_load_val(o_load_time_val_q),
        .i_stop(o_gen_stop_q), .o_tick(i_frame_tick), .o_valid(i_rd_valid), .o_time(i_rd_time),
        .o_gen_time(i_gen_time), .o_locked(i_gen_locked));
    assign i_rd_user = ~i_rd_time;
    assign i_gen_user = ~i_gen_time;
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    function automatic int frm(input logic [31:0] t);
        return (t[15:12] * 10 + t[11:8]) * 25 + t[7:4] * 10 + t[3:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata_q, e);
    endtask
    task automatic frames(input int n);
        repeat (n) @(posedge i_frame_tick);
    endtask
    // Writes land right after a tick, clear of any word in flight
    task automatic set_mode(input int m);
        frames(1);
        wr(4'h0, 32'(m));
        mode_m = m;
    endtask
    task automatic drop;
        frames(1);
        rd_en <= 1'b0;
    endtask
    task automatic resume;
        frames(1);
        rd_en <= 1'b1;
    endtask
    task automatic stop_chk(input int n, input logic e);
        frames(n);
        repeat (3) @(posedge i_sys_clk);
        #1 chk({31'h0, o_gen_stop_q}, {31'h0, e});
    endtask
    task automatic reset_dut;
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
    endtask
    task automatic final_report;
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------
    // Reference model of word acceptance
    // ----------------
    always @(negedge i_sys_clk) begin
        if (i_rst) begin
            last_m = -1;
            done_m = 0;
            cap_m = 0;
            wh_m = 4;
            // Start-up mode outlives a restart, everything else drops to off
            if (mode_m != 5)
                mode_m = 0;
            exp_q.delete();
        end else begin
            if (o_load_time_q) begin
                if (exp_q.size() == 0)
                    chk(32'h1, 32'h0);
                else
                    chk(32'(frm(o_load_time_val_q)), 32'(exp_q.pop_front()));
            end
            if (o_load_user_q)
                chk(o_load_user_val_q, ~o_load_time_val_q);
            if (i_frame_tick && cap_m > 0)
                cap_m = cap_m - 1;
            if (i_rd_valid) begin
                f = frm(i_rd_time);
                g = frm(i_gen_time);
                thr = (wh_m < 2 || wh_m > 20) ? 4 : wh_m;
                big = int'(f - g >= thr || g - f >= thr);
                ok = int'(last_m < 0 || f == last_m + 1);
                if (mode_m inside {7, 8})
                    ok = int'(last_m < 0 || f > last_m);
                acc = int'(mode_m == 6 || (ok != 0 && (mode_m inside {[1:4]}
                    || (mode_m == 9 && f % 25 == 0)
                    || (mode_m inside {7, 8} && (big != 0 || cap_m > 0))
                    || (mode_m == 5 && i_gen_locked && done_m == 0))));
                // Two seconds of frames at the 25 frame rate
                if (acc != 0 && big != 0 && mode_m inside {7, 8})
                    cap_m = 2 * 25;
                if (acc != 0 && mode_m == 1)
                    mode_m = 0;
                if (acc != 0 && mode_m == 5)
                    done_m = 1;
                if (acc != 0)
                    exp_q.push_back(f);
                last_m = f;
            end
        end
    end
    initial begin
        #60000;
        n_errors++;
        final_report;
    end
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        seed = 32'h5f0c;
        {i_rst, i_ce} = 2'b11;
        {i_wr, i_rd, rd_en, lock} = 4'h0;
        {i_addr, i_wdata, step} = 40'h0;
        {n_errors, total_checks} = 64'h0;
        step = 4'h1;
        base = 16'($random(seed)) & 16'h03ff;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h2, 32'h4);
        rd(4'hf, 32'h0);
        wv = $random(seed);
        wr(4'h2, {27'h0, wv[4:0]});
        rd(4'h2, {27'h0, wv[4:0]});
        for (int c = 0; c < 5; c++) begin
            wr(4'h1, 32'(c));
            rd(4'h1, 32'(c));
        end
        wr(4'h1, 32'h0);
        set_mode(1);
        reset_dut;
        rd(4'h0, 32'h0);
        rd_en <= 1'b1;
        set_mode(1);
        frames(3);
        rd(4'h0, 32'h0);
        set_mode(2);
        wr(4'h1, 32'h2);
        frames(3);
        step <= 4'h6;
        frames(1);
        step <= 4'h1;
        frames(3);
        drop;
        stop_chk(5, 1'b0);
        resume;
        wr(4'h2, 32'h3);
        wh_m = 3;
        wr(4'h1, 32'h0);
        set_mode(4);
        drop;
        stop_chk(3, 1'b0);
        stop_chk(2, 1'b1);
        resume;
        set_mode(3);
        drop;
        stop_chk(1, 1'b0);
        stop_chk(2, 1'b1);
        resume;
        set_mode(6);
        step <= 4'h0;
        frames(4);
        step <= 4'h1;
        drop;
        stop_chk(1, 1'b1);
        resume;
        set_mode(9);
        frames(30);
        step <= 4'h0;
        set_mode(7);
        frames(4);
        step <= 4'h1;
        drop;
        stop_chk(6, 1'b0);
        resume;
        frames(55);
        set_mode(8);
        drop;
        stop_chk(6, 1'b1);
        resume;
        set_mode(5);
        frames(3);
        lock <= 1'b1;
        frames(4);
        reset_dut;
        rd(4'h0, 32'h5);
        frames(4);
        chk(32'(exp_q.size()), 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
